// >>> hptrc_pkg.sv
// Constants for the host port transmit and receive control block
package hptrc_pkg;
	localparam int unsigned APB_ADDR_W = 8;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned REG_W = 16;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_TRANSMIT_CONTROL = 6'h00;
	localparam logic [5:0] IDX_TRANSMIT_STATUS = 6'h02;
	localparam logic [5:0] IDX_RECEIVE_CONTROL = 6'h04;
	localparam logic [5:0] IDX_GLOBAL_SOFT_RESET = 6'h06;
	localparam logic [5:0] IDX_BUS_WIDTH_CONFIG = 6'h08;

	// Field positions
	localparam int unsigned BIT_SOFT_RESET = 0;
	localparam int unsigned BIT_BUS_WIDTH_16 = 0;
	localparam int unsigned BIT_CFG_WORD_BUS = 0;
	localparam int unsigned BIT_TX_RUN = 0;
	localparam int unsigned BIT_TX_CRC = 1;
	localparam int unsigned BIT_TX_PAD = 2;
	localparam int unsigned BIT_TX_PAUSE = 3;
	localparam int unsigned BIT_RX_BAD_CRC = 9;
	localparam int unsigned BIT_RX_PAUSE = 10;
	localparam int unsigned TX_CTRL_W = 4;
	localparam int unsigned FRAME_ID_W = 6;
	localparam int unsigned UNIT_COUNT = 5;

	// Reset values
	localparam logic [TX_CTRL_W-1:0] TX_CTRL_RESET = 4'h0;
	localparam logic [FRAME_ID_W-1:0] FRAME_ID_RESET = 6'h00;
	localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;

	// Frame sizing
	localparam int unsigned LEN_W = 11;
	localparam int unsigned PAD_W = 7;
	localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 11'h040;

	// Pause quantum: 512 bit times at 100 Mb/s
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned PAUSE_QUANTUM_NS = 5120;
	localparam int unsigned PAUSE_QUANTUM_CYCLES = (PAUSE_QUANTUM_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned QUANTA_W = 16;

	typedef enum logic [1:0] {
		HPTRC_TX_STOPPED = 2'b00,
		HPTRC_TX_RUNNING = 2'b01,
		HPTRC_TX_DRAINING = 2'b10
	} hptrc_tx_state_t;
endpackage

// >>> hptrc_pad_calc.sv
// Short-frame padding length calculation
`timescale 1ns/1ps
module hptrc_pad_calc (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic soft_reset,
	input wire logic frame_start,
	input wire logic [hptrc_pkg::LEN_W-1:0] frame_length,
	input wire logic pad_enable,
	output logic [hptrc_pkg::PAD_W-1:0] pad_bytes
);
	import hptrc_pkg::*;

	logic [PAD_W-1:0] pad_q;
	logic [PAD_W-1:0] pad_d;
	logic [LEN_W-1:0] short_by;

	always_comb begin
		short_by = MIN_FRAME_BYTES - frame_length;
		pad_d = pad_q;
		if (soft_reset) begin
			pad_d = '0;
		end else if (frame_start) begin
			if (pad_enable && (frame_length < MIN_FRAME_BYTES)) begin
				pad_d = short_by[PAD_W-1:0];
			end else begin
				pad_d = '0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pad_q <= '0;
		end else begin
			pad_q <= pad_d;
		end
	end

	assign pad_bytes = pad_q;
endmodule

// >>> hptrc_top.sv
// Host port transmit and receive control registers with APB access
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module hptrc_top #(
	parameter int unsigned ADDR_W = hptrc_pkg::APB_ADDR_W,
	parameter int unsigned QUANTUM_CYCLES = hptrc_pkg::PAUSE_QUANTUM_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hptrc_pkg::APB_DATA_W-1:0] pwdata,
	output logic [hptrc_pkg::APB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic config_memory_enable_pin,
	input wire logic cfg_word_valid,
	input wire logic [hptrc_pkg::REG_W-1:0] cfg_word,
	output logic [hptrc_pkg::UNIT_COUNT-1:0] unit_soft_reset,
	output logic bus_width_16,
	input wire logic tx_frame_start,
	input wire logic [hptrc_pkg::LEN_W-1:0] tx_frame_length,
	input wire logic tx_frame_active,
	input wire logic tx_frame_done,
	input wire logic [hptrc_pkg::FRAME_ID_W-1:0] tx_done_frame_id,
	output logic tx_running,
	output logic tx_crc_append,
	output logic [hptrc_pkg::PAD_W-1:0] tx_pad_bytes,
	input wire logic rx_fifo_at_threshold,
	input wire logic switch_flow_ctrl_enable,
	output logic tx_pause_request,
	input wire logic rx_pause_received,
	input wire logic [hptrc_pkg::QUANTA_W-1:0] rx_pause_quanta,
	output logic tx_hold,
	input wire logic rx_frame_end,
	input wire logic rx_frame_crc_error,
	output logic rx_frame_admit,
	output logic rx_frame_discard
);
	import hptrc_pkg::*;

	localparam int unsigned PRESC_W = $clog2(QUANTUM_CYCLES + 1);
	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(QUANTUM_CYCLES - 1);

	// Bus interface state: only the hard reset touches it
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [APB_DATA_W-1:0] prdata_q;
	logic [APB_DATA_W-1:0] prdata_d;
	logic soft_q;
	logic soft_d;
	logic bus16_q;
	logic bus16_d;

	// Queue and MAC control state, cleared by soft reset too
	logic [TX_CTRL_W-1:0] transmit_control_q;
	logic [TX_CTRL_W-1:0] transmit_control_d;
	logic rx_pause_en_q;
	logic rx_pause_en_d;
	logic rx_bad_crc_q;
	logic rx_bad_crc_d;
	logic [FRAME_ID_W-1:0] frame_id_q;
	logic [FRAME_ID_W-1:0] frame_id_d;

	logic setup;
	logic access_wr;
	logic [5:0] idx;
	logic aligned;
	logic hit;
	logic [REG_W-1:0] rd_val;

	always_comb begin
		idx = 6'(paddr[ADDR_W-1:2]);
		aligned = (paddr[1:0] == 2'h0) && ((paddr >> 2) == ADDR_W'(idx));
		setup = psel && !penable;
		access_wr = psel && penable && pready_q && pwrite && !pslverr_q;
		hit = 1'b0;
		rd_val = REG_ZERO;
		case (idx)
			IDX_TRANSMIT_CONTROL: begin
				hit = 1'b1;
				rd_val[TX_CTRL_W-1:0] = transmit_control_q;
			end
			IDX_TRANSMIT_STATUS: begin
				hit = 1'b1;
				rd_val[FRAME_ID_W-1:0] = frame_id_q;
			end
			IDX_RECEIVE_CONTROL: begin
				hit = 1'b1;
				rd_val[BIT_RX_PAUSE] = rx_pause_en_q;
				rd_val[BIT_RX_BAD_CRC] = rx_bad_crc_q;
			end
			IDX_GLOBAL_SOFT_RESET: begin
				hit = 1'b1;
				rd_val[BIT_SOFT_RESET] = soft_q;
			end
			IDX_BUS_WIDTH_CONFIG: begin
				hit = 1'b1;
				rd_val[BIT_BUS_WIDTH_16] = bus16_q;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		hit = hit && aligned;
	end

	// No wait state: answer is prepared in setup so pready comes from a flop
	always_comb begin
		pready_d = setup;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (setup) begin
			pslverr_d = !hit;
			prdata_d = (hit && !pwrite) ? APB_DATA_W'(rd_val) : '0;
		end
	end

	always_comb begin
		soft_d = soft_q;
		if (access_wr && (idx == IDX_GLOBAL_SOFT_RESET)) begin
			soft_d = pwdata[BIT_SOFT_RESET];
		end
		bus16_d = bus16_q;
		if (!config_memory_enable_pin) begin
			bus16_d = 1'b0;
		end else if (cfg_word_valid) begin
			bus16_d = cfg_word[BIT_CFG_WORD_BUS];
		end
	end

	// Bus interface flops ignore the soft reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			soft_q <= 1'b0;
			bus16_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			soft_q <= soft_d;
			bus16_q <= bus16_d;
		end
	end

	always_comb begin
		transmit_control_d = transmit_control_q;
		rx_pause_en_d = rx_pause_en_q;
		rx_bad_crc_d = rx_bad_crc_q;
		frame_id_d = frame_id_q;
		if (soft_q) begin
			transmit_control_d = TX_CTRL_RESET;
			rx_pause_en_d = 1'b0;
			rx_bad_crc_d = 1'b0;
			frame_id_d = FRAME_ID_RESET;
		end else begin
			if (access_wr && (idx == IDX_TRANSMIT_CONTROL)) begin
				transmit_control_d = pwdata[TX_CTRL_W-1:0];
			end
			if (access_wr && (idx == IDX_RECEIVE_CONTROL)) begin
				rx_pause_en_d = pwdata[BIT_RX_PAUSE];
				rx_bad_crc_d = pwdata[BIT_RX_BAD_CRC];
			end
			if (tx_frame_done) begin
				frame_id_d = tx_done_frame_id;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			transmit_control_q <= TX_CTRL_RESET;
			rx_pause_en_q <= 1'b0;
			rx_bad_crc_q <= 1'b0;
			frame_id_q <= FRAME_ID_RESET;
		end else begin
			transmit_control_q <= transmit_control_d;
			rx_pause_en_q <= rx_pause_en_d;
			rx_bad_crc_q <= rx_bad_crc_d;
			frame_id_q <= frame_id_d;
		end
	end

	// Transmit run state
	hptrc_tx_state_t tx_state_q;
	hptrc_tx_state_t tx_state_d;

	always_comb begin
		tx_state_d = tx_state_q;
		case (tx_state_q)
			HPTRC_TX_STOPPED: begin
				if (transmit_control_q[BIT_TX_RUN]) begin
					tx_state_d = HPTRC_TX_RUNNING;
				end
			end
			HPTRC_TX_RUNNING: begin
				if (!transmit_control_q[BIT_TX_RUN]) begin
					tx_state_d = tx_frame_active ? HPTRC_TX_DRAINING : HPTRC_TX_STOPPED;
				end
			end
			HPTRC_TX_DRAINING: begin
				if (transmit_control_q[BIT_TX_RUN]) begin
					tx_state_d = HPTRC_TX_RUNNING;
				end else if (!tx_frame_active) begin
					tx_state_d = HPTRC_TX_STOPPED;
				end
			end
			default: begin
				tx_state_d = HPTRC_TX_STOPPED;
			end
		endcase
		if (soft_q) begin
			tx_state_d = HPTRC_TX_STOPPED;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_state_q <= HPTRC_TX_STOPPED;
		end else begin
			tx_state_q <= tx_state_d;
		end
	end

	// Pause timer; a new pause frame reloads it, as the link expects
	logic [QUANTA_W-1:0] quanta_q;
	logic [QUANTA_W-1:0] quanta_d;
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;

	always_comb begin
		quanta_d = quanta_q;
		presc_d = presc_q;
		if (soft_q || !rx_pause_en_q) begin
			quanta_d = '0;
			presc_d = '0;
		end else if (rx_pause_received) begin
			quanta_d = rx_pause_quanta;
			presc_d = '0;
		end else if (quanta_q != '0) begin
			if (presc_q == PRESC_LAST) begin
				presc_d = '0;
				quanta_d = quanta_q - 1'b1;
			end else begin
				presc_d = presc_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			quanta_q <= '0;
			presc_q <= '0;
		end else begin
			quanta_q <= quanta_d;
			presc_q <= presc_d;
		end
	end

	// Registered outputs toward the units
	logic [UNIT_COUNT-1:0] unit_rst_q;
	logic [UNIT_COUNT-1:0] unit_rst_d;
	logic tx_running_q;
	logic tx_running_d;
	logic tx_crc_q;
	logic tx_crc_d;
	logic pause_req_q;
	logic pause_req_d;
	logic hold_q;
	logic hold_d;
	logic admit_q;
	logic admit_d;
	logic discard_q;
	logic discard_d;

	always_comb begin
		tx_running_d = (tx_state_d == HPTRC_TX_RUNNING);
		tx_crc_d = transmit_control_d[BIT_TX_CRC];
		hold_d = (quanta_d != '0);
		unit_rst_d = {UNIT_COUNT{soft_q}};
		pause_req_d = transmit_control_q[BIT_TX_PAUSE] && switch_flow_ctrl_enable && rx_fifo_at_threshold && !soft_q;
		admit_d = rx_frame_end && !soft_q && (!rx_frame_crc_error || rx_bad_crc_q);
		discard_d = rx_frame_end && !soft_q && rx_frame_crc_error && !rx_bad_crc_q;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			unit_rst_q <= '0;
			tx_running_q <= 1'b0;
			tx_crc_q <= 1'b0;
			pause_req_q <= 1'b0;
			hold_q <= 1'b0;
			admit_q <= 1'b0;
			discard_q <= 1'b0;
		end else begin
			unit_rst_q <= unit_rst_d;
			tx_running_q <= tx_running_d;
			tx_crc_q <= tx_crc_d;
			pause_req_q <= pause_req_d;
			hold_q <= hold_d;
			admit_q <= admit_d;
			discard_q <= discard_d;
		end
	end

	// Padding length only; CRC pairing is left to software
	hptrc_pad_calc u_pad (
		.core_clk(core_clk),
		.resetn(resetn),
		.soft_reset(soft_q),
		.frame_start(tx_frame_start),
		.frame_length(tx_frame_length),
		.pad_enable(transmit_control_q[BIT_TX_PAD]),
		.pad_bytes(tx_pad_bytes)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign unit_soft_reset = unit_rst_q;
	assign bus_width_16 = bus16_q;
	assign tx_running = tx_running_q;
	assign tx_crc_append = tx_crc_q;
	assign tx_pause_request = pause_req_q;
	assign tx_hold = hold_q;
	assign rx_frame_admit = admit_q;
	assign rx_frame_discard = discard_q;
endmodule

// >>> hptrc_top_sva.sv
// Checker for the host port transmit and receive control block
`timescale 1ns/1ps
module hptrc_top_sva #(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic config_memory_enable_pin,
	input wire logic cfg_word_valid,
	input wire logic [15:0] cfg_word,
	input wire logic [4:0] unit_soft_reset,
	input wire logic bus_width_16,
	input wire logic tx_frame_start,
	input wire logic [10:0] tx_frame_length,
	input wire logic [6:0] tx_pad_bytes,
	input wire logic rx_fifo_at_threshold,
	input wire logic switch_flow_ctrl_enable,
	input wire logic tx_pause_request,
	input wire logic rx_pause_received,
	input wire logic tx_hold,
	input wire logic rx_frame_end,
	input wire logic rx_frame_crc_error,
	input wire logic rx_frame_admit,
	input wire logic rx_frame_discard
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	bus_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	units_together_a: assert property (unit_soft_reset == 5'h00 || unit_soft_reset == 5'h1f)
		else $error("units split");
	reset_held_a: assert property ($fell(unit_soft_reset[0]) |-> $past(psel && penable && pready && pwrite
		&& paddr == 8'h18 && !pwdata[0], 2)) else $error("early release");
	width_load_a: assert property (config_memory_enable_pin && cfg_word_valid |=> bus_width_16 == $past(cfg_word[0]))
		else $error("width not loaded");
	width_pin_a: assert property (!config_memory_enable_pin |=> !bus_width_16) else $error("width without pin");
	long_nopad_a: assert property (tx_frame_start && tx_frame_length >= 11'h040 |=> tx_pad_bytes == 7'h00)
		else $error("pad");
	pause_cause_a: assert property (tx_pause_request |-> $past(rx_fifo_at_threshold && switch_flow_ctrl_enable))
		else $error("pause without cause");
	hold_cause_a: assert property ($rose(tx_hold) |-> $past(rx_pause_received)) else $error("hold without pause");
	discard_cause_a: assert property (rx_frame_discard |-> $past(rx_frame_end && rx_frame_crc_error) && !rx_frame_admit)
		else $error("bad discard");
endmodule
bind hptrc_top hptrc_top_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// >>> hptrc_mac_model.sv
// MAC side traffic model facing the control block
`timescale 1ns/1ps
module hptrc_mac_model (
	input wire logic core_clk,
	input wire logic tx_running,
	input wire logic tx_hold,
	output logic tx_frame_start,
	output logic [10:0] tx_frame_length,
	output logic tx_frame_active,
	output logic tx_frame_done,
	output logic [5:0] tx_done_frame_id,
	output logic rx_pause_received,
	output logic [15:0] rx_pause_quanta,
	output logic rx_frame_end,
	output logic rx_frame_crc_error
);
	initial begin
		{tx_frame_start, tx_frame_length, tx_frame_active, tx_frame_done, tx_done_frame_id} = '0;
		{rx_pause_received, rx_pause_quanta, rx_frame_end, rx_frame_crc_error} = '0;
	end
	// Released lines show inverted data so a stale value cannot pass
	task tx_frame(input logic [10:0] len, input logic [5:0] id);
		@(posedge core_clk);
		if (tx_running && !tx_hold) begin
			tx_frame_start <= 1'b1;
			tx_frame_length <= len;
			tx_frame_active <= 1'b1;
			@(posedge core_clk);
			tx_frame_start <= 1'b0;
			tx_frame_length <= ~len;
			tx_frame_done <= 1'b1;
			tx_done_frame_id <= id;
			@(posedge core_clk);
			tx_frame_done <= 1'b0;
			tx_frame_active <= 1'b0;
			tx_done_frame_id <= ~id;
		end
	endtask
	task rx_frame(input logic bad);
		@(posedge core_clk);
		rx_frame_end <= 1'b1;
		rx_frame_crc_error <= bad;
		@(posedge core_clk);
		rx_frame_end <= 1'b0;
		rx_frame_crc_error <= ~bad;
	endtask
	task pause(input logic [15:0] q);
		@(posedge core_clk);
		rx_pause_received <= 1'b1;
		rx_pause_quanta <= q;
		@(posedge core_clk);
		rx_pause_received <= 1'b0;
		rx_pause_quanta <= ~q;
	endtask
endmodule

// >>> tb_host_port_tx_rx_control.sv
// Testbench for the host port transmit and receive control block
`timescale 1ns/1ps
module tb_host_port_tx_rx_control;
	import hptrc_pkg::*;
	logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, pin = 1'b0, cfg_v = 1'b0, thr = 1'b0, swfc = 1'b0;
	logic [15:0] cfg_word = 16'h0000;
	logic [4:0] units;
	logic bw16, tx_running, tx_crc, preq, tx_hold, admit, discard, fs, fa, fd, pr, fe, fce;
	logic [6:0] pad;
	logic [10:0] flen;
	logic [5:0] fid;
	logic [15:0] quanta;
	int fail_count = 0, checks = 0;
	logic [5:0] ix [5] = '{IDX_TRANSMIT_CONTROL, IDX_TRANSMIT_STATUS, IDX_RECEIVE_CONTROL,
		IDX_GLOBAL_SOFT_RESET, IDX_BUS_WIDTH_CONFIG};
	always #2.5 core_clk = ~core_clk;
	hptrc_top #(.QUANTUM_CYCLES(4)) dut (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.config_memory_enable_pin(pin), .cfg_word_valid(cfg_v), .cfg_word(cfg_word), .unit_soft_reset(units),
		.bus_width_16(bw16), .tx_frame_start(fs), .tx_frame_length(flen), .tx_frame_active(fa),
		.tx_frame_done(fd), .tx_done_frame_id(fid), .tx_running(tx_running), .tx_crc_append(tx_crc),
		.tx_pad_bytes(pad), .rx_fifo_at_threshold(thr), .switch_flow_ctrl_enable(swfc), .tx_pause_request(preq),
		.rx_pause_received(pr), .rx_pause_quanta(quanta), .tx_hold(tx_hold), .rx_frame_end(fe),
		.rx_frame_crc_error(fce), .rx_frame_admit(admit), .rx_frame_discard(discard));
	hptrc_mac_model mac (.core_clk(core_clk), .tx_running(tx_running), .tx_hold(tx_hold), .tx_frame_start(fs),
		.tx_frame_length(flen), .tx_frame_active(fa), .tx_frame_done(fd), .tx_done_frame_id(fid),
		.rx_pause_received(pr), .rx_pause_quanta(quanta), .rx_frame_end(fe), .rx_frame_crc_error(fce));
	task tally_and_finish;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Called just after a rising edge; ends one idle edge later
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fail_count++;
			tally_and_finish;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task wr(input logic [5:0] i, input logic [31:0] d);
		apb(1'b1, {i, 2'b00}, d);
	endtask
	task rc(input logic [5:0] i, input logic [31:0] e);
		apb(1'b0, {i, 2'b00}, 32'h0);
		chk(rdat, e);
	endtask
	task settle;
		repeat (3) @(posedge core_clk);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		foreach (ix[k]) rc(ix[k], 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		$display("test reset values done");
		wr(IDX_TRANSMIT_CONTROL, 32'hffff);
		settle;
		rc(IDX_TRANSMIT_CONTROL, 32'h000f);
		chk({tx_running, tx_crc}, 32'h3);
		mac.tx_frame(11'd20, 6'h2a);
		@(posedge core_clk);
		chk(pad, 32'd44);
		rc(IDX_TRANSMIT_STATUS, 32'h2a);
		mac.tx_frame(11'd64, 6'h15);
		@(posedge core_clk);
		chk(pad, 32'd0);
		rc(IDX_TRANSMIT_STATUS, 32'h15);
		wr(IDX_TRANSMIT_CONTROL, 32'h3);
		mac.tx_frame(11'd20, 6'h01);
		@(posedge core_clk);
		chk(pad, 32'd0);
		thr <= 1'b1;
		swfc <= 1'b1;
		settle;
		chk(preq, 32'h0);
		wr(IDX_TRANSMIT_CONTROL, 32'hb);
		settle;
		chk(preq, 32'h1);
		swfc <= 1'b0;
		settle;
		chk(preq, 32'h0);
		wr(IDX_TRANSMIT_CONTROL, 32'h0);
		settle;
		chk(tx_running, 32'h0);
		$display("test transmit done");
		wr(IDX_RECEIVE_CONTROL, 32'hffff);
		rc(IDX_RECEIVE_CONTROL, 32'h0600);
		mac.rx_frame(1'b1);
		@(posedge core_clk);
		chk(admit, 32'h1);
		mac.pause(16'h1);
		@(posedge core_clk);
		chk(tx_hold, 32'h1);
		repeat (10) @(posedge core_clk);
		chk(tx_hold, 32'h0);
		wr(IDX_RECEIVE_CONTROL, 32'h0);
		mac.rx_frame(1'b1);
		@(posedge core_clk);
		chk({admit, discard}, 32'h1);
		mac.pause(16'h1);
		@(posedge core_clk);
		chk(tx_hold, 32'h0);
		$display("test receive done");
		pin <= 1'b1;
		cfg_word <= 16'h0001;
		cfg_v <= 1'b1;
		@(posedge core_clk);
		cfg_v <= 1'b0;
		settle;
		chk(bw16, 32'h1);
		wr(IDX_BUS_WIDTH_CONFIG, 32'h0);
		rc(IDX_BUS_WIDTH_CONFIG, 32'h1);
		wr(IDX_TRANSMIT_CONTROL, 32'h3);
		wr(IDX_GLOBAL_SOFT_RESET, 32'h1);
		settle;
		chk(units, 32'h1f);
		rc(IDX_GLOBAL_SOFT_RESET, 32'h1);
		rc(IDX_TRANSMIT_CONTROL, 32'h0);
		rc(IDX_BUS_WIDTH_CONFIG, 32'h1);
		chk({tx_running, tx_crc}, 32'h0);
		rc(IDX_TRANSMIT_STATUS, 32'h0);
		repeat (10) @(posedge core_clk);
		chk(units, 32'h1f);
		wr(IDX_GLOBAL_SOFT_RESET, 32'h0);
		settle;
		chk(units, 32'h0);
		pin <= 1'b0;
		settle;
		chk(bw16, 32'h0);
		wr(IDX_GLOBAL_SOFT_RESET, 32'h1);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk(units, 32'h0);
		rc(IDX_GLOBAL_SOFT_RESET, 32'h0);
		$display("test soft reset done");
		tally_and_finish;
	end
endmodule
